// ---- src/ucp_defines.svh ----
// offsets, field positions, reset values and timing counts of the block
`ifndef UCP_DEFINES_SVH
`define UCP_DEFINES_SVH

// register port
`define UCP_ADDR_W      7
`define UCP_UC_ADDR     7'h6a
`define UCP_PC_ADDR     7'h6b
`define UCP_UC_RST      8'h00
`define UCP_PC_RST      8'h00

// user control fields
`define UCP_UC_ENGINE   7
`define UCP_UC_FIFO     6
`define UCP_UC_AUX      5
`define UCP_UC_TWDIS    4
`define UCP_UC_ENG_RST  3

// power control fields
`define UCP_PC_DEV_RST  7
`define UCP_PC_SLEEP    6
`define UCP_PC_CYCLE    5
`define UCP_PC_GSTBY    4
`define UCP_PC_THERMO   3

// clock source codes
`define UCP_CS_OSC_A    3'h0
`define UCP_CS_OSC_B    3'h6
`define UCP_CS_HALT     3'h7

// pulse vector slots
`define UCP_P_SIG       0
`define UCP_P_AUX       1
`define UCP_P_FIFO      2
`define UCP_P_ENG       3
`define UCP_P_TW        4
`define UCP_P_DEV       5

// timing: one oscillator cycle, as whole system clock cycles
`define UCP_CLK_NS      5
`define UCP_OSC_NS      50
`define UCP_PULSE_CYC   ((`UCP_OSC_NS + `UCP_CLK_NS - 1) / `UCP_CLK_NS)
`define UCP_CLK_HZ      64'd200_000_000
`define UCP_WAKE0_MHZ   64'd1250
`define UCP_WAKE1_MHZ   64'd5000
`define UCP_WAKE2_MHZ   64'd20000
`define UCP_WAKE3_MHZ   64'd40000
`define UCP_LP_MAX_SH   4'hb

`endif

// ---- src/ucp_pkg.sv ----
// types shared by the user control and power block
package ucp_pkg;

  typedef enum logic [1:0] {UCP_CLK_OSC, UCP_CLK_AUTO, UCP_CLK_HALT}
    ucp_clk_mode_t;

  typedef struct packed {
    logic [7:0] count;
    logic       active;
  } ucp_pulse_state_t;

  typedef struct packed {
    logic [31:0] count;
    logic        wake;
  } ucp_timer_state_t;

  typedef struct packed {
    logic [2:0] uc_en;
    logic [6:0] pc;
    logic       engine_active;
    logic       spi_only;
    logic [1:0] pin_s1;
    logic [1:0] pin_s2;
    logic [1:0] pin_s3;
    logic [1:0] pin_lvl;
    logic [7:0] rdata;
  } ucp_top_state_t;

endpackage

// ---- src/ucp_pulse.sv ----
// self-clearing reset pulse of a fixed number of clock cycles
module ucp_pulse
  import ucp_pkg::*;
#(
  parameter int CYCLES = 10
)
(
  // clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // request and pulse
  input  wire logic fire,
  output logic      active
);

  ucp_pulse_state_t q;
  ucp_pulse_state_t d;

  if (CYCLES < 1 || CYCLES > 255)
  begin : g_chk
    $error("ucp_pulse: CYCLES out of range");
  end

  // a new request restarts the count, so a late one is never cut short
  always_comb
  begin
    d = q;
    d.count = (q.count == 8'h00) ? 8'h00 : q.count - 8'h01;
    if (fire)
    begin
      d.count = 8'(CYCLES);
    end
    d.active = (d.count != 8'h00);
  end

  // state register
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign active = q.active;

endmodule

// ---- src/ucp_wake_timer.sv ----
// periodic wake strobe for the cycle mode
module ucp_wake_timer
  import ucp_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // control
  input  wire logic        run,
  input  wire logic [31:0] period,
  // strobe
  output logic             wake
);

  ucp_timer_state_t q;
  ucp_timer_state_t d;

  // counting restarts from zero whenever the mode is left
  always_comb
  begin
    d = q;
    d.wake = 1'b0;
    if (!run)
    begin
      d.count = 32'h0000_0000;
    end
    else if (q.count + 32'h0000_0001 >= period)
    begin
      d.count = 32'h0000_0000;
      d.wake = 1'b1;
    end
    else
    begin
      d.count = q.count + 32'h0000_0001;
    end
  end

  // state register
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign wake = q.wake;

endmodule

// ---- src/ucp_top.sv ----
// user control and power control registers with their reset pulses
//
// Contract
// - engine enable bit 7 runs engine; clearing stops after current round
// - bit 6 enables host fifo access; internal fifo writes unaffected
// - bit 5 enables aux master and isolates aux pins, else pins follow host
// - enabled engine runs with all sensors off, except at 8kHz rate
// - bit 4 resets two-wire slave, locks spi only, clears after osc cycle
// - bit 3 resets engine only while engine enable is zero, then clears
// - bit 2 pulses fifo asynchronous reset for one oscillator cycle
// - bit 1 pulses aux master asynchronous reset for one oscillator cycle
// - bit 0 resets gyro, accel, thermo paths and clears sensor data
// - power bit 7 restores all registers to defaults, then clears
// - power bit 6 puts the whole device to sleep
// - cycle bit, without sleep or standby, alternates sleep and one sample
// - cycle mode with all accel axes off wakes but takes no sample
// - gyro standby keeps drive and pll, switches sense paths off
// - power bit 3 switches the temperature sensor off
// - clock codes 0 and 6 use oscillator; 1 to 5 pll when ready
// - clock code 7 stops the clock and holds timing generator reset
`include "ucp_defines.svh"

module ucp_top
  import ucp_pkg::*;
#(
  parameter int          PULSE_CYC = `UCP_PULSE_CYC,
  parameter int unsigned WAKE0_CYC =
    32'(`UCP_CLK_HZ * 64'd1000 / `UCP_WAKE0_MHZ),
  parameter int unsigned WAKE1_CYC =
    32'(`UCP_CLK_HZ * 64'd1000 / `UCP_WAKE1_MHZ),
  parameter int unsigned WAKE2_CYC =
    32'(`UCP_CLK_HZ * 64'd1000 / `UCP_WAKE2_MHZ),
  parameter int unsigned WAKE3_CYC =
    32'(`UCP_CLK_HZ * 64'd1000 / `UCP_WAKE3_MHZ),
  parameter int unsigned LP_BASE_CYC = WAKE0_CYC
)
(
  // clock and reset
  input  wire logic                   clock,
  input  wire logic                   rst,
  // register port from the serial host interface
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  input  wire logic [`UCP_ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]             reg_wdata,
  output logic      [7:0]             reg_rdata,
  // status from the rest of the device
  input  wire logic                   engine_round_done,
  input  wire logic                   sensors_all_off,
  input  wire logic                   rate_is_8khz,
  input  wire logic                   pll_ready,
  input  wire logic                   compat_mode,
  input  wire logic [3:0]             lowpower_sample_rate,
  input  wire logic [1:0]             legacy_wake_rate,
  input  wire logic [2:0]             accel_axis_off,
  // host pins and aux master drive
  input  wire logic                   host_data_pin,
  input  wire logic                   host_clock_pin,
  input  wire logic                   aux_master_data_low,
  input  wire logic                   aux_master_clock_low,
  // aux open-drain pins
  output logic                        aux_data_pin_out,
  output logic                        aux_data_pin_oe,
  output logic                        aux_clock_pin_out,
  output logic                        aux_clock_pin_oe,
  // enables and modes
  output logic                        motion_engine_run,
  output logic                        fifo_host_access_en,
  output logic                        aux_master_on,
  output logic                        spi_only,
  output logic                        sleep_mode,
  output logic                        gyro_drive_on,
  output logic                        gyro_sense_on,
  output logic                        thermo_sensor_off,
  output logic                        clk_use_pll,
  output logic                        clk_stopped,
  output logic                        timing_gen_rst,
  output logic                        cycle_wake,
  output logic                        cycle_sample,
  // reset pulses
  output logic                        host_twowire_rst,
  output logic                        motion_engine_rst,
  output logic                        fifo_rst,
  output logic                        aux_master_rst,
  output logic [2:0]                  sensor_path_rst,
  output logic                        sensor_regs_clear,
  output logic                        regs_to_default
);

  ucp_top_state_t q;
  ucp_top_state_t d;
  logic           wr_uc;
  logic           wr_pc;
  logic [5:0]     fire;
  logic [5:0]     act;
  logic [1:0]     agree;
  logic [31:0]    period;
  ucp_clk_mode_t  cmode;

  if (PULSE_CYC < 1 || PULSE_CYC > 255 || WAKE3_CYC < 1
      || LP_BASE_CYC < 1)
  begin : g_chk
    $error("ucp_top: timing parameter out of range");
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------

  // clock source decode
  function automatic ucp_clk_mode_t clk_mode(input logic [2:0] code);
    if (code == `UCP_CS_HALT)
    begin
      return UCP_CLK_HALT;
    end
    if (code == `UCP_CS_OSC_A || code == `UCP_CS_OSC_B)
    begin
      return UCP_CLK_OSC;
    end
    return UCP_CLK_AUTO;
  endfunction

  // low-power wake period; deep codes saturate to keep the count sane
  function automatic logic [31:0] lp_period(input logic [3:0] code);
    logic [3:0] sh;
    sh = (code > `UCP_LP_MAX_SH) ? `UCP_LP_MAX_SH : code;
    return LP_BASE_CYC >> sh;
  endfunction

  // ------------------------------------------------------------
  // register access
  // ------------------------------------------------------------

  // writes are dropped while the device reset pulse is running
  assign wr_uc = reg_wr && reg_addr == `UCP_UC_ADDR && !act[`UCP_P_DEV];
  assign wr_pc = reg_wr && reg_addr == `UCP_PC_ADDR && !act[`UCP_P_DEV];

  // engine reset gated by the written enable
  assign fire[2:0] = wr_uc ? reg_wdata[2:0] : 3'h0;
  assign fire[`UCP_P_ENG] = wr_uc && reg_wdata[`UCP_UC_ENG_RST]
                            && !reg_wdata[`UCP_UC_ENGINE];
  assign fire[`UCP_P_TW] = wr_uc && reg_wdata[`UCP_UC_TWDIS];
  assign fire[`UCP_P_DEV] = wr_pc && reg_wdata[`UCP_PC_DEV_RST];

  for (genvar i = 0; i < 6; i++)
  begin : g_pulse
    ucp_pulse #(.CYCLES(PULSE_CYC)) u_pulse
    (
      .clock  (clock),
      .rst    (rst),
      .fire   (fire[i]),
      .active (act[i])
    );
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------

  // a host pin level counts once the second and third stages agree
  assign agree = ~(q.pin_s2 ^ q.pin_s3);

  always_comb
  begin
    d = q;
    d.pin_s1 = {host_data_pin, host_clock_pin};
    d.pin_s2 = q.pin_s1;
    d.pin_s3 = q.pin_s2;
    d.pin_lvl = (q.pin_s3 & agree) | (q.pin_lvl & ~agree);
    // defaults held for the whole pulse
    if (act[`UCP_P_DEV])
    begin
      d.uc_en = 3'(`UCP_UC_RST >> 5);
      d.pc = 7'(`UCP_PC_RST & 8'h7f);
    end
    else
    begin
      if (wr_uc)
      begin
        d.uc_en = reg_wdata[7:5];
      end
      if (wr_pc)
      begin
        d.pc = reg_wdata[6:0];
      end
    end
    // spi lock stays until the block reset
    if (fire[`UCP_P_TW])
    begin
      d.spi_only = 1'b1;
    end
    // stop only at the end of a round
    if (q.uc_en[2])
    begin
      d.engine_active = 1'b1;
    end
    else if (engine_round_done)
    begin
      d.engine_active = 1'b0;
    end
    // pulse bits read back as their live state
    d.rdata = 8'h00;
    if (reg_rd && reg_addr == `UCP_UC_ADDR)
    begin
      d.rdata = {q.uc_en, act[4:0]};
    end
    else if (reg_rd && reg_addr == `UCP_PC_ADDR)
    begin
      d.rdata = {act[`UCP_P_DEV], q.pc};
    end
  end

  // state register
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      q <= '0;
      q.uc_en <= 3'(`UCP_UC_RST >> 5);
      q.pc <= 7'(`UCP_PC_RST & 8'h7f);
    end
    else
    begin
      q <= d;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------

  assign reg_rdata = q.rdata;
  assign cmode = clk_mode(q.pc[2:0]);

  // engine idles only with bare sensors at the fastest rate
  assign motion_engine_run = q.engine_active
                             && !(sensors_all_off && rate_is_8khz);
  assign fifo_host_access_en = q.uc_en[1];
  assign aux_master_on = q.uc_en[0];
  assign spi_only = q.spi_only;

  // open-drain pins: master drive or host pin follow
  assign aux_data_pin_out = 1'b0;
  assign aux_clock_pin_out = 1'b0;
  assign aux_data_pin_oe = q.uc_en[0] ? aux_master_data_low
                                      : !q.pin_lvl[1];
  assign aux_clock_pin_oe = q.uc_en[0] ? aux_master_clock_low
                                       : !q.pin_lvl[0];

  assign sleep_mode = q.pc[`UCP_PC_SLEEP];
  assign gyro_drive_on = !q.pc[`UCP_PC_SLEEP];
  assign gyro_sense_on = !q.pc[`UCP_PC_SLEEP] && !q.pc[`UCP_PC_GSTBY];
  assign thermo_sensor_off = q.pc[`UCP_PC_THERMO];

  assign clk_use_pll = cmode == UCP_CLK_AUTO && pll_ready;
  assign clk_stopped = cmode == UCP_CLK_HALT;
  assign timing_gen_rst = cmode == UCP_CLK_HALT;

  always_comb
  begin
    period = lp_period(lowpower_sample_rate);
    if (compat_mode)
    begin
      unique case (legacy_wake_rate)
        2'h0: period = WAKE0_CYC;
        2'h1: period = WAKE1_CYC;
        2'h2: period = WAKE2_CYC;
        2'h3: period = WAKE3_CYC;
      endcase
    end
  end

  // cycle only without sleep or standby
  ucp_wake_timer u_wake
  (
    .clock  (clock),
    .rst    (rst),
    .run    (q.pc[`UCP_PC_CYCLE] && !q.pc[`UCP_PC_SLEEP]
             && !q.pc[`UCP_PC_GSTBY]),
    .period (period),
    .wake   (cycle_wake)
  );

  // wake without sample when all axes are off
  assign cycle_sample = cycle_wake && !(&accel_axis_off);

  assign host_twowire_rst = act[`UCP_P_TW];
  assign motion_engine_rst = act[`UCP_P_ENG];
  assign fifo_rst = act[`UCP_P_FIFO];
  assign aux_master_rst = act[`UCP_P_AUX];
  assign sensor_path_rst = {3{act[`UCP_P_SIG]}};
  assign sensor_regs_clear = act[`UCP_P_SIG];
  assign regs_to_default = act[`UCP_P_DEV];

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // helper: cycles the fifo pulse has stood since its last request;
  // a counter, because a ten-fold repetition is too costly to unroll
  logic [7:0] fifo_run_q;

  always_ff @(posedge clock)
  begin
    if (rst || fire[`UCP_P_FIFO])
    begin
      fifo_run_q <= 8'h00;
    end
    else if (fifo_rst && fifo_run_q != 8'hff)
    begin
      fifo_run_q <= fifo_run_q + 8'h01;
    end
  end

  a_fifo_pulse_len: assert property (
    (fifo_rst |-> fifo_run_q < 8'(PULSE_CYC))
    and ($fell(fifo_rst) |-> fifo_run_q == 8'(PULSE_CYC)))
    else $error("fifo reset pulse length wrong");
  a_twowire_lock: assert property (
    fire[`UCP_P_TW] |=> spi_only && host_twowire_rst)
    else $error("two-wire reset did not lock spi");
  a_engine_round: assert property (
    q.engine_active && !q.uc_en[2] && !engine_round_done
    |=> q.engine_active)
    else $error("engine stopped mid round");
  a_engine_rst_gate: assert property (
    $rose(motion_engine_rst) |-> $past(!reg_wdata[7] && wr_uc))
    else $error("engine reset while enabled");
  a_engine_bare: assert property (
    q.engine_active && !rate_is_8khz |-> motion_engine_run)
    else $error("engine idle with sensors off");
  a_sleep_no_wake: assert property (
    q.pc[`UCP_PC_SLEEP] |=> !cycle_wake)
    else $error("wake strobe while asleep");
  a_clock_halt: assert property (
    q.pc[2:0] == `UCP_CS_HALT |-> timing_gen_rst && !clk_use_pll)
    else $error("halt code did not stop clock");
  a_pll_pick: assert property (
    clk_use_pll |-> pll_ready && q.pc[2:0] != `UCP_CS_OSC_A
                    && q.pc[2:0] != `UCP_CS_OSC_B)
    else $error("pll chosen for oscillator code");
  a_dev_defaults: assert property (
    regs_to_default |=> q.pc == 7'(`UCP_PC_RST & 8'h7f)
                        && q.uc_en == 3'(`UCP_UC_RST >> 5))
    else $error("device reset left registers");
  a_aux_bypass: assert property (
    !aux_master_on |-> aux_data_pin_oe == !q.pin_lvl[1])
    else $error("aux pin not following host");

endmodule

// ---- verification/ucp_host_model.sv ----
// host model: serial host issuing register reads and writes
`include "ucp_defines.svh"

module ucp_host_model
  import ucp_pkg::*;
(
  // clock
  input  wire logic                   clock,
  // register port
  output logic                        reg_wr,
  output logic                        reg_rd,
  output logic      [`UCP_ADDR_W-1:0] reg_addr,
  output logic      [7:0]             reg_wdata,
  input  wire logic [7:0]             reg_rdata
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle bus at time zero
  initial
  begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 7'h00;
    reg_wdata = 8'h00;
  end

  // one write; the idle bus is scrambled so stale values never match
  task automatic write(input logic [6:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask

  // one read; data is taken in the cycle after the strobe
  task automatic read(input logic [6:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    #1 d = reg_rdata;
  endtask

  // full reset, pause, write of 0x07 to address 0x68, which the block ignores, pause
  task automatic spi_reset(input int pause);
    write(7'h6b, 8'h80);
    repeat (pause) @(posedge clock);
    write(7'h68, 8'h07);
    repeat (pause) @(posedge clock);
  endtask
endmodule

// ---- verification/testbench.sv ----
// self-checking bench for the user control and power block
module testbench
  import ucp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ------------------------------------------------------------------
  // signals and design
  // ------------------------------------------------------------------
  localparam int PW = 10;
  localparam logic [6:0] UC = 7'h6a;
  localparam logic [6:0] PC = 7'h6b;

  typedef struct packed {
    logic [6:0] a;
    logic [7:0] d;
    logic       pll;
    logic [8:0] e;
  } ucp_row_t;

  logic       clock = 1'b0;
  logic       rst = 1'b1;
  logic       engine_round_done = 1'b0, sensors_all_off = 1'b0;
  logic       rate_is_8khz = 1'b0, pll_ready = 1'b0, compat_mode = 1'b0;
  logic       host_data_pin = 1'b1, host_clock_pin = 1'b1;
  logic       aux_master_data_low = 1'b0, aux_master_clock_low = 1'b0;
  logic [3:0] lowpower_sample_rate = 4'h0;
  logic [1:0] legacy_wake_rate = 2'h0;
  logic [2:0] accel_axis_off = 3'h0;
  logic       reg_wr, reg_rd, aux_data_pin_out, aux_data_pin_oe;
  logic       aux_clock_pin_out, aux_clock_pin_oe, motion_engine_run;
  logic       fifo_host_access_en, aux_master_on, spi_only, sleep_mode;
  logic       gyro_drive_on, gyro_sense_on, thermo_sensor_off;
  logic       clk_use_pll, clk_stopped, timing_gen_rst, cycle_wake;
  logic       cycle_sample, host_twowire_rst, motion_engine_rst;
  logic       fifo_rst, aux_master_rst, sensor_regs_clear, regs_to_default;
  logic [2:0] sensor_path_rst;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rd;
  int         mismatches = 0, compares = 0, n, w, s;
  ucp_row_t   rows [13];

  // wake periods shortened so cycle mode fits a short run; the pulse
  // length stays at its default of PW cycles
  ucp_top #(.WAKE0_CYC(20), .WAKE1_CYC(10), .WAKE2_CYC(5),
    .WAKE3_CYC(3), .LP_BASE_CYC(40)) DUT (.clock, .rst, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata, .engine_round_done,
    .sensors_all_off, .rate_is_8khz, .pll_ready, .compat_mode,
    .lowpower_sample_rate, .legacy_wake_rate, .accel_axis_off,
    .host_data_pin, .host_clock_pin, .aux_master_data_low,
    .aux_master_clock_low, .aux_data_pin_out, .aux_data_pin_oe,
    .aux_clock_pin_out, .aux_clock_pin_oe, .motion_engine_run,
    .fifo_host_access_en, .aux_master_on, .spi_only, .sleep_mode,
    .gyro_drive_on, .gyro_sense_on, .thermo_sensor_off, .clk_use_pll,
    .clk_stopped, .timing_gen_rst, .cycle_wake, .cycle_sample,
    .host_twowire_rst, .motion_engine_rst, .fifo_rst, .aux_master_rst,
    .sensor_path_rst, .sensor_regs_clear, .regs_to_default);

  ucp_host_model host (.clock, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata);

  // 200 MHz clock
  initial
  begin
    forever #2.5 clock = ~clock;
  end

  // comparison with a one-line report on mismatch
  task automatic check(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  // pulse output by slot; the path reset counts only when all lines agree
  function automatic logic pick(input int sel);
    case (sel)
      0: pick = &{sensor_path_rst, sensor_regs_clear};
      1: pick = aux_master_rst;
      2: pick = fifo_rst;
      3: pick = motion_engine_rst;
      4: pick = host_twowire_rst;
      default: pick = regs_to_default;
    endcase
  endfunction

  // cycles a pulse stays high from now, bounded in case it sticks
  task automatic width(input int sel, output int cnt);
    #1 cnt = 0;
    while (pick(sel) === 1'b1 && cnt < 40)
    begin
      cnt++;
      @(posedge clock);
      #1;
    end
  endtask

  // wake strobes and sample strobes over a span of cycles
  task automatic wakes(input int cyc, output int wk, output int sm);
    wk = 0;
    sm = 0;
    repeat (cyc)
    begin
      @(posedge clock);
      #1;
      wk += int'(cycle_wake === 1'b1);
      sm += int'(cycle_sample === 1'b1);
    end
  endtask

  task automatic tally_and_finish();
    if (mismatches == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // a hang is cut short well past the expected run length
  initial
  begin
    repeat (20000) @(posedge clock);
    mismatches++;
    tally_and_finish();
  end

  // ------------------------------------------------------------------
  // tests
  // ------------------------------------------------------------------
  initial
  begin
    // outputs {fifo, aux, sleep, drive, sense, thermo, pll, stop, tgr}
    rows = '{'{PC, 8'h00, 1'b1, 9'h030}, '{PC, 8'h01, 1'b1, 9'h034},
      '{PC, 8'h02, 1'b1, 9'h034}, '{PC, 8'h03, 1'b0, 9'h030},
      '{PC, 8'h04, 1'b1, 9'h034}, '{PC, 8'h05, 1'b1, 9'h034},
      '{PC, 8'h06, 1'b1, 9'h030}, '{PC, 8'h07, 1'b1, 9'h033},
      '{PC, 8'h40, 1'b1, 9'h040}, '{PC, 8'h10, 1'b1, 9'h020},
      '{PC, 8'h08, 1'b1, 9'h038}, '{7'h68, 8'hff, 1'b1, 9'h038},
      '{UC, 8'h40, 1'b1, 9'h138}};
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    host.read(UC, rd);
    check("user reset value", 8'h00, rd);
    host.read(PC, rd);
    check("power reset value", 8'h00, rd);
    check("spi lock at reset", 1'b0, spi_only);
    foreach (rows[i])
    begin
      @(posedge clock);
      pll_ready <= rows[i].pll;
      host.write(rows[i].a, rows[i].d);
      #1;
      check("mode outputs", rows[i].e, {fifo_host_access_en, aux_master_on,
        sleep_mode, gyro_drive_on, gyro_sense_on, thermo_sensor_off,
        clk_use_pll, clk_stopped, timing_gen_rst});
      host.read(rows[i].a, rd);
      check("readback", rows[i].a[6:1] == 6'h35 ? rows[i].d : 8'h00, rd);
    end
    // every user pulse: live while running, zero afterwards; aux is idle
    for (int b = 0; b < 5; b++)
    begin
      host.write(UC, 8'(1 << b));
      host.read(UC, rd);
      check("live pulse bit", 8'(1 << b), rd);
      width(b, n);
      check("pulse length", PW - 2, n);
      host.read(UC, rd);
      check("cleared pulse bit", 8'h00, rd);
    end
    check("spi lock", 1'b1, spi_only);
    // device reset restores defaults and refuses writes meanwhile
    host.write(PC, 8'h48);
    host.write(UC, 8'h60);
    host.write(PC, 8'h80);
    host.write(UC, 8'h40);
    width(5, n);
    check("default restore length", PW - 2, n);
    host.read(PC, rd);
    check("power after restore", 8'h00, rd);
    host.read(UC, rd);
    check("user after restore", 8'h00, rd);
    check("spi lock kept", 1'b1, spi_only);
    // engine reset ignored while enabled; engine finishes its round
    host.write(UC, 8'h88);
    width(3, n);
    check("gated engine reset", 0, n);
    @(posedge clock);
    #1 check("engine running", 1'b1, motion_engine_run);
    @(posedge clock);
    sensors_all_off <= 1'b1;
    @(posedge clock);
    #1 check("engine sensors off", 1'b1, motion_engine_run);
    @(posedge clock);
    rate_is_8khz <= 1'b1;
    @(posedge clock);
    #1 check("engine at 8khz", 1'b0, motion_engine_run);
    @(posedge clock);
    rate_is_8khz <= 1'b0;
    host.write(UC, 8'h00);
    repeat (4) @(posedge clock);
    #1 check("engine mid round", 1'b1, motion_engine_run);
    @(posedge clock);
    engine_round_done <= 1'b1;
    repeat (3) @(posedge clock);
    #1 check("engine stopped", 1'b0, motion_engine_run);
    // aux pins follow the host pins, then the master when it is on
    for (int v = 0; v < 2; v++)
    begin
      @(posedge clock);
      host_data_pin <= v[0];
      host_clock_pin <= v[0];
      repeat (8) @(posedge clock);
      #1 check("pins follow host", {2'b00, ~v[0], ~v[0]},
        {aux_data_pin_out, aux_clock_pin_out, aux_data_pin_oe,
        aux_clock_pin_oe});
    end
    host.write(UC, 8'h20);
    #1 check("aux master on", 1'b1, aux_master_on);
    for (int v = 0; v < 2; v++)
    begin
      @(posedge clock);
      aux_master_data_low <= v[0];
      aux_master_clock_low <= ~v[0];
      host_data_pin <= ~v[0];
      repeat (8) @(posedge clock);
      #1 check("pins isolated", {v[0], ~v[0]},
        {aux_data_pin_oe, aux_clock_pin_oe});
    end
    // cycle mode at the legacy and low-power rates, then in sleep
    @(posedge clock);
    compat_mode <= 1'b1;
    legacy_wake_rate <= 2'h1;
    host.write(PC, 8'h20);
    wakes(100, w, s);
    check("legacy wake count", 1, w >= 9 && w <= 11);
    check("sample count", w, s);
    @(posedge clock);
    accel_axis_off <= 3'h7;
    compat_mode <= 1'b0;
    lowpower_sample_rate <= 4'h2;
    wakes(20, w, s);
    wakes(100, w, s);
    check("low power wake count", 1, w >= 9 && w <= 11);
    check("samples axes off", 0, s);
    host.write(PC, 8'h60);
    wakes(100, w, s);
    check("wakes in sleep", 0, w);
    host.spi_reset(20);
    host.read(PC, rd);
    check("power after host reset", 8'h00, rd);
    tally_and_finish();
  end
endmodule
